// ==== core/lct_cell.sv ====
// logic cell: xor or set/reset flip-flop followed by a selectable timer stage
`timescale 1ns/1ps
// Notes on behaviour
// - code 40: output is plain xor of inputs
// - on-delay: high after period, low at once
// - off-delay: high at once, low after period
// - single pulse of period length on rise
// - restartable pulse: new rise restarts full period
// - pulse train: alternate high/low periods while high
// - codes 50-55: set wins when both asserted
// - codes 60-65: reset wins when both asserted
// - through stage follows logic result directly
module lct_cell #(
    parameter int PERIOD_W = lct_pkg::PERIOD_W_DEF,   // timer period width
    parameter int TICK_DIV = lct_pkg::TICK_DIV_DEF    // clocks per timebase tick
) (
    input  wire logic                sys_clk,      // 20 MHz system clock
    input  wire logic                resetn,       // async reset, active low
    input  wire logic                sync_clr,     // synchronous clear, same domain
    input  wire logic [7:0]          block_sel,    // block-selection code
    input  wire logic [PERIOD_W-1:0] period_ticks, // timer period in ticks
    input  wire logic                in_a,         // first input, or set
    input  wire logic                in_b,         // second input, or reset
    output logic                     cell_out      // cell output, from a flop
);

    // ---- code decode: tens digit and units digit
    // true when the code lies among the ten codes that start at base
    function automatic logic in_family(input logic [7:0] code, input logic [7:0] base);
        in_family = (code >= base) && (code < 8'(base + lct_pkg::SEL_SPAN));
    endfunction
    // one decode per family, so the three ranges cannot drift apart
    wire logic    in_xor  = in_family(block_sel, lct_pkg::SEL_XOR_BASE);
    wire logic    in_setp = in_family(block_sel, lct_pkg::SEL_SETP_BASE);
    wire logic    in_rstp = in_family(block_sel, lct_pkg::SEL_RSTP_BASE);
    wire lct_pkg::lct_fn_e fn_sel = in_xor  ? lct_pkg::LCT_FN_XOR  :
                                    in_setp ? lct_pkg::LCT_FN_SETP :
                                    in_rstp ? lct_pkg::LCT_FN_RSTP : lct_pkg::LCT_FN_NONE;
    wire logic [7:0] base  = in_xor  ? lct_pkg::SEL_XOR_BASE  :
                             in_setp ? lct_pkg::SEL_SETP_BASE : lct_pkg::SEL_RSTP_BASE;
    wire logic [7:0] unit8 = block_sel - base;
    wire logic [3:0] stage = unit8[3:0];   // units digit; 6..9 behave as through

    // ---- flip-flop state of the set/reset functions
    logic sr_ff;       // stored flip-flop state
    logic nxt_sr;
    // set-priority and reset-priority differ only when both inputs are high
    assign nxt_sr = (fn_sel == lct_pkg::LCT_FN_SETP) ? (in_a | (sr_ff & ~in_b)) :
                    (fn_sel == lct_pkg::LCT_FN_RSTP) ? (~in_b & (in_a | sr_ff)) :
                    sr_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sr_ff <= lct_pkg::RST_LEVEL;
        end else if (sync_clr) begin
            sr_ff <= lct_pkg::RST_LEVEL;
        end else begin
            sr_ff <= nxt_sr;
        end
    end

    // stage input is the selected function result; xor is combinational
    wire logic fn_res = (fn_sel == lct_pkg::LCT_FN_XOR) ? (in_a ^ in_b) :
                        (fn_sel == lct_pkg::LCT_FN_NONE) ? 1'b0 : nxt_sr;

    // ---- timebase: one tick every TICK_DIV clocks
    localparam int DIV_W = $clog2(TICK_DIV + 1);
    logic [DIV_W-1:0] div_ff;   // tick prescaler
    wire  logic       tick = (div_ff == DIV_W'(TICK_DIV - 1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= (tick || sync_clr) ? '0 : div_ff + 1'b1;
        end
    end

    // ---- timer stage
    logic                in_d_ff;   // previous stage input for edge detect
    logic [PERIOD_W-1:0] cnt_ff;    // ticks elapsed in current interval
    logic                run_ff;    // timer running
    logic                nxt_out;
    logic                nxt_run;
    logic [PERIOD_W-1:0] nxt_cnt;
    wire  logic rise   = fn_res & ~in_d_ff;
    wire  logic fall   = ~fn_res & in_d_ff;
    // the period has elapsed when the count reaches the programmed value;
    // a period of zero ends on the first tick rather than never
    wire  logic expire = run_ff && tick && (cnt_ff + 1'b1 >= period_ticks);
    wire  logic [PERIOD_W-1:0] cnt_inc = tick ? cnt_ff + 1'b1 : cnt_ff;

    // next state of the timer and output per stage mode
    always_comb begin
        nxt_out = cell_out;
        nxt_run = run_ff;
        nxt_cnt = cnt_inc;
        unique case (stage)
            lct_pkg::STG_ON_DELAY: begin
                if (!fn_res) begin
                    nxt_out = 1'b0;
                    nxt_run = 1'b0;
                    nxt_cnt = '0;
                end else if (rise) begin
                    nxt_run = 1'b1;
                    nxt_cnt = '0;
                end else if (expire) begin
                    nxt_out = 1'b1;
                    nxt_run = 1'b0;
                end
            end
            lct_pkg::STG_OFF_DELAY: begin
                if (fn_res) begin
                    nxt_out = 1'b1;
                    nxt_run = 1'b0;
                    nxt_cnt = '0;
                end else if (fall) begin
                    nxt_run = 1'b1;
                    nxt_cnt = '0;
                end else if (expire) begin
                    nxt_out = 1'b0;
                    nxt_run = 1'b0;
                end
            end
            lct_pkg::STG_SINGLE: begin
                // a rise during the pulse is ignored
                if (rise && !run_ff) begin
                    nxt_out = 1'b1;
                    nxt_run = 1'b1;
                    nxt_cnt = '0;
                end else if (expire) begin
                    nxt_out = 1'b0;
                    nxt_run = 1'b0;
                end
            end
            lct_pkg::STG_RESTART: begin
                if (rise) begin
                    nxt_out = 1'b1;
                    nxt_run = 1'b1;
                    nxt_cnt = '0;
                end else if (expire) begin
                    nxt_out = 1'b0;
                    nxt_run = 1'b0;
                end
            end
            lct_pkg::STG_TRAIN: begin
                if (!fn_res) begin
                    nxt_out = 1'b0;
                    nxt_run = 1'b0;
                    nxt_cnt = '0;
                end else if (rise) begin
                    nxt_out = 1'b1;
                    nxt_run = 1'b1;
                    nxt_cnt = '0;
                end else if (expire) begin
                    nxt_out = ~cell_out;
                    nxt_cnt = '0;
                end
            end
            default: begin
                nxt_out = fn_res;
                nxt_run = 1'b0;
                nxt_cnt = '0;
            end
        endcase
    end

    // output and timer registers; output follows with one flop of latency
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            in_d_ff  <= lct_pkg::RST_LEVEL;
            cnt_ff   <= '0;
            run_ff   <= lct_pkg::RST_LEVEL;
            cell_out <= lct_pkg::RST_LEVEL;
        end else if (sync_clr) begin
            in_d_ff  <= lct_pkg::RST_LEVEL;
            cnt_ff   <= '0;
            run_ff   <= lct_pkg::RST_LEVEL;
            cell_out <= lct_pkg::RST_LEVEL;
        end else begin
            in_d_ff  <= fn_res;
            cnt_ff   <= nxt_cnt;
            run_ff   <= nxt_run;
            cell_out <= nxt_out;
        end
    end

    // ---- assertions
    a_xor_through: assert property (@(posedge sys_clk) disable iff (!resetn)
        (block_sel == lct_pkg::SEL_XOR_BASE && !sync_clr) |=> cell_out == $past(in_a ^ in_b))
        else $error("xor through output wrong");
    a_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
        (in_setp && in_a && in_b && !sync_clr) |=> sr_ff)
        else $error("set priority lost");
    a_reset_wins: assert property (@(posedge sys_clk) disable iff (!resetn)
        (in_rstp && in_a && in_b && !sync_clr) |=> !sr_ff)
        else $error("reset priority lost");
    a_on_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
        (stage == lct_pkg::STG_ON_DELAY && fn_sel != lct_pkg::LCT_FN_NONE && !fn_res)
        |=> !cell_out)
        else $error("on-delay did not drop at once");
    a_off_rise: assert property (@(posedge sys_clk) disable iff (!resetn)
        (stage == lct_pkg::STG_OFF_DELAY && fn_sel != lct_pkg::LCT_FN_NONE &&
         fn_res && !sync_clr) |=> cell_out)
        else $error("off-delay did not rise at once");
    sequence s_pulse_start;
        stage == lct_pkg::STG_SINGLE && rise && !run_ff && !sync_clr;
    endsequence
    a_single_start: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_pulse_start |=> cell_out && run_ff)
        else $error("single pulse not started");
    a_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
        (stage == lct_pkg::STG_RESTART && rise && !sync_clr) |=> cell_out && cnt_ff == '0)
        else $error("restartable pulse not restarted");
    a_train_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        (stage == lct_pkg::STG_TRAIN && !fn_res) |=> !cell_out && !run_ff)
        else $error("pulse train active with input low");
    a_sync_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        sync_clr |=> !cell_out && !sr_ff && cnt_ff == '0)
        else $error("synchronous clear incomplete");

endmodule // lct_cell

// ==== include/lct_pkg.sv ====
// package of constants and types for the logic cell with timer stage
package lct_pkg;
    // block-selection tens digit: logic function
    localparam logic [7:0] SEL_XOR_BASE  = 8'h28;   // code 40
    localparam logic [7:0] SEL_SETP_BASE = 8'h32;   // code 50
    localparam logic [7:0] SEL_RSTP_BASE = 8'h3c;   // code 60
    localparam logic [7:0] SEL_SPAN      = 8'h0a;   // ten codes per family
    // units digit: timer stage
    localparam logic [3:0] STG_THROUGH   = 4'h0;
    localparam logic [3:0] STG_ON_DELAY  = 4'h1;
    localparam logic [3:0] STG_OFF_DELAY = 4'h2;
    localparam logic [3:0] STG_SINGLE    = 4'h3;
    localparam logic [3:0] STG_RESTART   = 4'h4;
    localparam logic [3:0] STG_TRAIN     = 4'h5;
    // reset values
    localparam logic       RST_LEVEL     = 1'b0;
    // default width and timebase divider
    localparam int         PERIOD_W_DEF  = 16;
    localparam int         TICK_DIV_DEF  = 20000;  // 1 ms timebase at 20 MHz
    // logic function selector
    typedef enum logic [1:0] {
        LCT_FN_XOR  = 2'b00,
        LCT_FN_SETP = 2'b01,
        LCT_FN_RSTP = 2'b10,
        LCT_FN_NONE = 2'b11
    } lct_fn_e;
endpackage

// ==== verif/lct_drive_model.sv ====
// drive-controller side model that presents the two cell inputs as registered levels
`timescale 1ns/1ps
module lct_drive_model (
    input  wire logic sys_clk, // system clock
    input  wire logic cmd_a,   // requested level of first signal
    input  wire logic cmd_b,   // requested level of second signal
    output logic      in_a,    // first cell input
    output logic      in_b     // second cell input
);
    // both levels start low so the cell sees no edge straight out of reset
    initial begin
        in_a = 1'b0;
        in_b = 1'b0;
    end
    // launch on the falling edge, so the levels are settled at the cell's rising edge
    always @(negedge sys_clk) begin
        in_a <= cmd_a;
        in_b <= cmd_b;
    end
endmodule // lct_drive_model

// ==== verif/test_lct_cell.sv ====
// self-checking testbench for the logic cell with timer stage
`timescale 1ns/1ps
module test_lct_cell;
    localparam int TD = 2;            // short timebase, so the run stays brief
    localparam int P  = 3;            // timer period in ticks
    localparam int LO = (P - 1) * TD; // shortest span the prescaler jitter allows
    localparam int HI = P * TD + 2;   // longest span, with two cycles of slack
    localparam int P2  = 5;               // second period, proves it is programmable
    localparam int LO2 = (P2 - 1) * TD;   // shortest span for the second period
    localparam int HI2 = P2 * TD + 2;     // longest span for the second period
    logic sys_clk = 1'b0;             // 20 MHz clock
    logic resetn = 1'b0;              // async reset, active low
    logic sync_clr = 1'b0;            // synchronous clear
    logic [7:0] block_sel = 8'h28;    // selection code
    logic [15:0] period_ticks = 16'h0003; // matches P
    logic cmd_a = 1'b0;               // requested first input
    logic cmd_b = 1'b0;               // requested second input
    logic in_a;                       // first input from the model
    logic in_b;                       // second input from the model
    logic cell_out;                   // output under test
    int failures = 0;                 // mismatches seen
    int samples_checked = 0;          // comparisons made
    always #25 sys_clk = ~sys_clk;
    lct_drive_model lct_drive_model_inst (.sys_clk(sys_clk), .cmd_a(cmd_a), .cmd_b(cmd_b),
        .in_a(in_a), .in_b(in_b));
    lct_cell #(.PERIOD_W(16), .TICK_DIV(TD)) lct_cell_inst (.sys_clk(sys_clk), .resetn(resetn),
        .sync_clr(sync_clr), .block_sel(block_sel), .period_ticks(period_ticks),
        .in_a(in_a), .in_b(in_b), .cell_out(cell_out));
    // compare the output level now
    task automatic chk(input logic exp, input string what);
        samples_checked++;
        if (cell_out !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // count the cycles the output keeps one level and judge the span
    task automatic span(input logic v, input int lo, input int hi, input string what);
        int n = 0;
        while (cell_out === v && n <= hi) begin
            @(negedge sys_clk);
            n++;
        end
        samples_checked++;
        if (n < lo || n > hi) begin
            failures++;
            $display("CHECK FAILED at %0t: %s span %0d", $time, what, n);
        end
    endtask
    // request new input levels; they reach the cell one cycle later
    task automatic put(input logic a, input logic b);
        @(negedge sys_clk);
        cmd_a <= a;
        cmd_b <= b;
        @(negedge sys_clk);
    endtask
    // select a code and clear the cell with both inputs low
    task automatic start(input logic [7:0] code);
        @(negedge sys_clk);
        block_sel = code;
        sync_clr = 1'b1;
        put(1'b0, 1'b0);
        @(negedge sys_clk);
        sync_clr = 1'b0;
    endtask
    // code 40: every input pair, output follows at once
    task automatic t_xor;
        start(8'h28);
        for (int i = 0; i < 4; i++) begin
            put(i[0], i[1]);
            @(negedge sys_clk);
            chk(i[0] ^ i[1], "xor through");
        end
        // units digit 6 has no timer and must pass the result through
        start(8'h2e);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        chk(1'b1, "spare unit digit through");
    endtask
    // flip-flop priority when set and reset meet
    task automatic t_ff;
        start(8'h32);
        put(1'b1, 1'b1);
        @(negedge sys_clk);
        chk(1'b1, "set wins");
        start(8'h3c);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        @(negedge sys_clk);
        chk(1'b0, "reset wins");
        // a code outside the three families forces the result low
        start(8'h46);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        chk(1'b0, "code outside families");
    endtask
    // code 61: delayed rise, immediate fall
    task automatic t_on;
        start(8'h3d);
        put(1'b1, 1'b0);
        span(1'b0, LO, HI + 2, "on delay");
        put(1'b0, 1'b1);
        // the level reaches the cell now; its answer stands one edge later
        @(negedge sys_clk);
        chk(1'b0, "on delay drop");
        // a longer programmed period must lengthen the delay
        period_ticks = 16'(P2);
        put(1'b1, 1'b0);
        span(1'b0, LO2, HI2 + 2, "long on delay");
        period_ticks = 16'(P);
    endtask
    // code 52: immediate rise, delayed fall, flip-flop holding between
    task automatic t_off;
        start(8'h34);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        chk(1'b1, "off delay rise");
        put(1'b0, 1'b0);
        // wait past a full period, so a lost state would show as a drop
        repeat (HI) @(negedge sys_clk);
        chk(1'b1, "state held");
        put(1'b0, 1'b1);
        span(1'b1, LO - 1, HI, "off delay");
    endtask
    // code 63: one pulse while the input stays high
    task automatic t_single;
        start(8'h3f);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        chk(1'b1, "pulse rise");
        span(1'b1, LO - 1, HI, "pulse length");
        @(negedge sys_clk);
        chk(1'b0, "no second pulse");
    endtask
    // code 44: a second rise mid-pulse restarts the full length
    task automatic t_restart;
        start(8'h2c);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        span(1'b1, LO, HI + 1, "restart");
    endtask
    // code 45: alternating levels while the input is high
    task automatic t_train;
        start(8'h2d);
        put(1'b1, 1'b0);
        @(negedge sys_clk);
        span(1'b1, LO - 1, HI, "train high");
        span(1'b0, LO - 1, HI, "train low");
        span(1'b1, LO - 1, HI, "train high again");
        span(1'b0, LO - 1, HI, "train low again");
        // drop the input inside a high interval, so the stop is visible
        put(1'b0, 1'b0);
        @(negedge sys_clk);
        chk(1'b0, "train stop");
    endtask
    // synchronous clear in the middle of an off delay
    task automatic t_clr;
        start(8'h2a);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
        sync_clr = 1'b1;
        @(negedge sys_clk);
        chk(1'b0, "clear mid delay");
        sync_clr = 1'b0;
        @(negedge sys_clk);
        chk(1'b0, "stays clear");
    endtask
    // print the counts and the verdict, then stop
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence: reset for five cycles, then each scenario
    initial begin
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        t_xor();   $display("xor test ended");
        t_ff();    $display("flip-flop test ended");
        t_on();    $display("on delay test ended");
        t_off();   $display("off delay test ended");
        t_single(); $display("single pulse test ended");
        t_restart(); $display("restart test ended");
        t_train(); $display("train test ended");
        t_clr();   $display("clear test ended");
        finish_test();
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #250000;
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // test_lct_cell
